// file: common/szc_pkg.sv
// constants, types and helpers of the speed reference filter and zero clamp
// assumes a 20 MHz system clock and an APB register port with 32-bit data
package szc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 50;          // system clock period
  localparam int SAMPLE_NS = 10000;    // filter sample period, 0.01 ms
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYC - 1);
  localparam logic [5:0] DIV_STEPS = 6'h21;  // quotient bits of the lag step
  localparam int GAIN_SHIFT = 8;       // gain is 8.8 fixed point

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_FILT_TC = 8'h00;
  localparam logic [7:0] OFS_CLAMP_LEVEL = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h0C;
  localparam logic [7:0] OFS_POS_GAIN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_HOLD_POS = 8'h18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int MODE_METHOD_LSB = 0;
  localparam int MODE_ALLOC_BIT = 4;
  localparam int MODE_CLAMPSEL_LSB = 8;
  localparam int STAT_REF_LSB = 16;
  localparam logic [15:0] TC_RST = 16'h0028;
  localparam logic [15:0] LEVEL_RST = 16'h000A;
  localparam logic [15:0] MAX_SPEED_RST = 16'h1388;
  localparam logic [15:0] GAIN_RST = 16'h0100;
  localparam logic [3:0] METHOD_RST = 4'h0;
  localparam logic ALLOC_RST = 1'b0;
  localparam logic [3:0] CLAMPSEL_RST = 4'h8;
  localparam logic [3:0] CLAMPSEL_ALWAYS = 4'h7;
  localparam logic [3:0] METHOD_ZERO_SW = 4'hA;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {CTRL_SPEED, CTRL_INTERNAL, CTRL_POSITION, CTRL_FORCE} szc_ctrl_e;
  typedef enum logic {CLAMP_FREE, CLAMP_HOLD} szc_clamp_e;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] szcAbs(input logic signed [31:0] v);
    szcAbs = v[31] ? 32'(-v) : 32'(v);
  endfunction : szcAbs

  function automatic logic signed [15:0] szcSat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) szcSat16 = 16'sh7FFF;
    else if (v < -48'sh7FFF) szcSat16 = -16'sh7FFF;
    else szcSat16 = v[15:0];
  endfunction : szcSat16

endpackage : szc_pkg

// file: core/szc_hold_loop.sv
// position hold loop: speed command from the stored clamp position
// assumes the feedback counter runs on the system clock
`timescale 1ns/10ps
module szc_hold_loop (
  // clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // loop inputs
  input wire logic enable,
  input wire logic signed [31:0] holdPos,
  input wire logic signed [31:0] posFb,
  input wire logic [15:0] gain,
  // speed command
  output logic signed [15:0] cmdOut
);
  import szc_pkg::*;

  logic signed [31:0] posErr;
  logic signed [47:0] prod;
  logic errSmall;

  // error of one pulse or less counts as in place
  assign posErr = holdPos - posFb;
  assign errSmall = szcAbs(posErr) <= 32'h0000_0001;
  assign prod = 48'(posErr * $signed({1'b0, gain})) >>> GAIN_SHIFT;

  // proportional pull back toward the stored position
  always_ff @(posedge sysClk) begin
    if (rst) begin
      cmdOut <= 16'sh0;
    end else if (!enable || errSmall) begin
      cmdOut <= 16'sh0;
    end else begin
      cmdOut <= szcSat16(prod);
    end
  end

  chk_hold_dead: assert property (@(posedge sysClk) disable iff (rst)
    (enable && errSmall) |=> (cmdOut == 16'sh0))
    else $error("command not zero within one pulse");

  // both push directions; a unity or larger gain must give a nonzero pull
  chk_hold_return: assert property (@(posedge sysClk) disable iff (rst)
    (enable && !errSmall && gain >= 16'h0100)
    |=> (cmdOut != 16'sh0 && cmdOut[15] == $past(posErr[31])))
    else $error("command does not pull back toward the clamp position");

endmodule : szc_hold_loop

// file: core/szc_lag_filter.sv
// first-order lag on the speed reference, one step per sample tick
// assumes the tick spacing exceeds the serial divide time
`timescale 1ns/10ps
module szc_lag_filter (
  // clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // sample and settings
  input wire logic sampleTick,
  input wire logic signed [15:0] refIn,
  input wire logic [15:0] timeConst,
  // result
  output logic signed [15:0] filtOut,
  output logic busy
);
  import szc_pkg::*;

  logic signed [31:0] acc_r;
  logic [32:0] quo_r;
  logic [16:0] rem_r;
  logic [15:0] div_r;
  logic neg_r;
  logic [5:0] step_r;
  logic signed [32:0] diff;
  logic [16:0] remShift;

  // the step toward the input is (x - y) * Ts / Tc, Ts equals one tc unit
  assign diff = 33'($signed({refIn, 16'h0000})) - 33'(acc_r);
  assign remShift = {rem_r[15:0], quo_r[32]};
  assign filtOut = acc_r[31:16];

  // ****************************************************************
  // accumulator and serial divider
  // ****************************************************************
  // serial divide keeps the area small; 33 cycles fit inside one sample
  always_ff @(posedge sysClk) begin
    if (rst) begin
      acc_r <= 32'sh0;
      quo_r <= 33'h0;
      rem_r <= 17'h0;
      div_r <= 16'h0;
      neg_r <= 1'b0;
      step_r <= 6'h0;
      busy <= 1'b0;
    end else if (sampleTick && timeConst == 16'h0000) begin
      acc_r <= {refIn, 16'h0000};
      busy <= 1'b0;
    end else if (sampleTick && !busy) begin
      neg_r <= diff[32];
      quo_r <= diff[32] ? 33'(-diff) : 33'(diff);
      rem_r <= 17'h0;
      div_r <= timeConst;  // new constant used from this sample on
      step_r <= 6'h0;
      busy <= 1'b1;
    end else if (busy) begin
      if (remShift >= {1'b0, div_r}) begin
        rem_r <= remShift - {1'b0, div_r};
        quo_r <= {quo_r[31:0], 1'b1};
      end else begin
        rem_r <= remShift;
        quo_r <= {quo_r[31:0], 1'b0};
      end
      step_r <= step_r + 6'h01;
      if (step_r == DIV_STEPS - 6'h01) begin
        busy <= 1'b0;
      end
    end else if (step_r == DIV_STEPS) begin
      acc_r <= neg_r ? acc_r - quo_r[31:0] : acc_r + quo_r[31:0];
      step_r <= 6'h0;
    end
  end

  chk_pass_through: assert property (@(posedge sysClk) disable iff (rst)
    (sampleTick && timeConst == 16'h0000) |=> (filtOut == $past(refIn)))
    else $error("zero time constant did not pass the input");

  chk_step_bound: assert property (@(posedge sysClk) disable iff (rst)
    (sampleTick && !busy && timeConst != 16'h0000) |=> busy ##[33:34] !busy)
    else $error("lag step did not finish in 33 cycles");

endmodule : szc_lag_filter

// file: core/szc_top.sv
// speed reference filter and zero clamp with an APB register port
// assumes pins are asynchronous; reference and feedback come on sysClk
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
//
// Contract
// - lag filter on reference, settable constant
// - clamp when request and reference below level
// - while clamped, ignore reference, hold position
// - hold within one pulse of entry position
// - push back when moved by force
// - method A uses proportional input as request
// - inactive request input disables clamp
// - allocation mode 1 uses selected clamp pin
// - clamp only for methods 0,3,4,5,6,7,9,A
// - switching away from speed modes drops clamp
// - clamp allocation 7 means always requested; the code requests only while CTRL_SPEED is active
// - clamp level register, default 10
// - threshold capped at maximum speed
module szc_top (
  // clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // discrete input pins, closed is low except ctrlSelectIn, which is active high
  input wire logic propCtrlInN,
  input wire logic [6:0] clampPinsN,
  input wire logic ctrlSelectIn,
  // reference and feedback
  input wire logic signed [15:0] speedRefIn,
  input wire logic signed [31:0] posFb,
  // drive outputs
  output logic signed [15:0] speedCmd_r,
  output logic clampActive
);
  import szc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [15:0] timeConst_r;
  logic [15:0] clampLevel_r;
  logic [15:0] maxSpeed_r;
  logic [15:0] posGain_r;
  logic [3:0] method_r;
  logic allocMode_r;
  logic [3:0] clampSel_r;
  logic [8:0] pinMeta_r;
  logic [8:0] pinSync_r;
  logic [7:0] sampleCnt_r;
  logic sampleTick;
  logic signed [15:0] filtRef;
  logic filtBusy;
  logic signed [15:0] holdCmd;
  logic signed [31:0] holdPos_r;
  szc_clamp_e clamp_r;
  szc_clamp_e clamp_nxt;
  szc_ctrl_e activeCtrl;
  logic methodOk;
  logic modeOk;
  logic pconOn;
  logic cselOn;
  logic [6:0] clampPinOn;
  logic clampReq;
  logic [15:0] effLevel;
  logic belowLevel;
  logic clampWant;
  logic addrHit;
  logic [31:0] readMux;
  logic wrEn;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // two flops on every pin; only the second stage is read
  always_ff @(posedge sysClk) begin
    if (rst) begin
      pinMeta_r <= 9'h1FF;
      pinSync_r <= 9'h1FF;
    end else begin
      pinMeta_r <= {ctrlSelectIn, propCtrlInN, clampPinsN};
      pinSync_r <= pinMeta_r;
    end
  end

  assign clampPinOn = ~pinSync_r[6:0];
  assign pconOn = ~pinSync_r[7];
  assign cselOn = pinSync_r[8];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait states: read data is latched in the setup cycle
  assign pready = psel & penable;
  assign pslverr = pready & ~addrHit;
  assign wrEn = psel & penable & pwrite & addrHit;

  // address decode and read mux
  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      OFS_FILT_TC: readMux = {16'h0000, timeConst_r};
      OFS_CLAMP_LEVEL: readMux = {16'h0000, clampLevel_r};
      OFS_MODE: begin
        readMux[MODE_METHOD_LSB +: 4] = method_r;
        readMux[MODE_ALLOC_BIT] = allocMode_r;
        readMux[MODE_CLAMPSEL_LSB +: 4] = clampSel_r;
      end
      OFS_MAX_SPEED: readMux = {16'h0000, maxSpeed_r};
      OFS_POS_GAIN: readMux = {16'h0000, posGain_r};
      OFS_STATUS: begin
        readMux[0] = clamp_r == CLAMP_HOLD;
        readMux[1] = methodOk & modeOk;
        readMux[2] = clampReq;
        readMux[3] = filtBusy;  // lag step in progress
        readMux[5:4] = activeCtrl;
        readMux[STAT_REF_LSB +: 16] = filtRef;
      end
      OFS_HOLD_POS: readMux = holdPos_r;
      default: addrHit = 1'b0;
    endcase
  end

  // read data register
  always_ff @(posedge sysClk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readMux;
    end
  end

  // settings take effect on the write edge
  always_ff @(posedge sysClk) begin
    if (rst) begin
      timeConst_r <= TC_RST;
      clampLevel_r <= LEVEL_RST;
      maxSpeed_r <= MAX_SPEED_RST;
      posGain_r <= GAIN_RST;
      method_r <= METHOD_RST;
      allocMode_r <= ALLOC_RST;
      clampSel_r <= CLAMPSEL_RST;
    end else if (wrEn) begin
      case (paddr)
        OFS_FILT_TC: timeConst_r <= pwdata[15:0];
        OFS_CLAMP_LEVEL: clampLevel_r <= pwdata[15:0] > 16'h2710 ? 16'h2710 : pwdata[15:0];
        OFS_MODE: begin
          method_r <= pwdata[MODE_METHOD_LSB +: 4];
          allocMode_r <= pwdata[MODE_ALLOC_BIT];
          clampSel_r <= pwdata[MODE_CLAMPSEL_LSB +: 4];
        end
        OFS_MAX_SPEED: maxSpeed_r <= pwdata[15:0];
        OFS_POS_GAIN: posGain_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // reference filter
  // ****************************************************************
  // sample tick every 0.01 ms, the unit of the time constant
  always_ff @(posedge sysClk) begin
    if (rst) begin
      sampleCnt_r <= 8'h00;
    end else if (sampleCnt_r == SAMPLE_LAST) begin
      sampleCnt_r <= 8'h00;
    end else begin
      sampleCnt_r <= sampleCnt_r + 8'h01;
    end
  end

  assign sampleTick = sampleCnt_r == SAMPLE_LAST;

  szc_lag_filter uFilter (
    .sysClk(sysClk),
    .rst(rst),
    .sampleTick(sampleTick),
    .refIn(speedRefIn),
    .timeConst(timeConst_r),
    .filtOut(filtRef),
    .busy(filtBusy)
  );

  // ****************************************************************
  // control method and clamp request
  // ****************************************************************
  // the select input picks between the two methods of a switching mode
  always_comb begin
    methodOk = 1'b1;
    activeCtrl = CTRL_SPEED;
    case (method_r)
      4'h0: activeCtrl = CTRL_SPEED;
      4'h3: activeCtrl = CTRL_INTERNAL;
      4'h4: activeCtrl = cselOn ? CTRL_SPEED : CTRL_INTERNAL;
      4'h5: activeCtrl = cselOn ? CTRL_POSITION : CTRL_INTERNAL;
      4'h6: activeCtrl = cselOn ? CTRL_FORCE : CTRL_INTERNAL;
      4'h7: activeCtrl = cselOn ? CTRL_SPEED : CTRL_POSITION;
      4'h9: activeCtrl = cselOn ? CTRL_SPEED : CTRL_FORCE;
      METHOD_ZERO_SW: activeCtrl = CTRL_SPEED;
      default: methodOk = 1'b0;
    endcase
  end

  // position or force phase of a switching method drops the clamp
  assign modeOk = activeCtrl == CTRL_SPEED || activeCtrl == CTRL_INTERNAL;

  // request source follows the allocation settings
  always_comb begin
    if (clampSel_r == CLAMPSEL_ALWAYS) begin
      clampReq = activeCtrl == CTRL_SPEED;
    end else if (!allocMode_r) begin
      clampReq = method_r == METHOD_ZERO_SW && pconOn;
    end else if (clampSel_r < CLAMPSEL_ALWAYS) begin
      clampReq = clampPinOn[clampSel_r[2:0]];
    end else begin
      clampReq = 1'b0;
    end
  end

  // a level above the motor limit is cut to the limit
  assign effLevel = clampLevel_r > maxSpeed_r ? maxSpeed_r : clampLevel_r;
  assign belowLevel = szcAbs(32'(filtRef)) < {16'h0000, effLevel};
  assign clampWant = methodOk && modeOk && clampReq && belowLevel;

  // ****************************************************************
  // clamp state
  // ****************************************************************
  always_comb begin
    case (clamp_r)
      CLAMP_FREE: clamp_nxt = clampWant ? CLAMP_HOLD : CLAMP_FREE;
      CLAMP_HOLD: clamp_nxt = clampWant ? CLAMP_HOLD : CLAMP_FREE;
      default: clamp_nxt = CLAMP_FREE;
    endcase
  end

  always_ff @(posedge sysClk) begin
    if (rst) begin
      clamp_r <= CLAMP_FREE;
    end else begin
      clamp_r <= clamp_nxt;
    end
  end

  // position is captured on the entry edge only
  always_ff @(posedge sysClk) begin
    if (rst) begin
      holdPos_r <= 32'sh0;
    end else if (clamp_r == CLAMP_FREE && clamp_nxt == CLAMP_HOLD) begin
      holdPos_r <= posFb;
    end
  end

  assign clampActive = clamp_r == CLAMP_HOLD;

  szc_hold_loop uHold (
    .sysClk(sysClk),
    .rst(rst),
    .enable(clampActive),
    .holdPos(holdPos_r),
    .posFb(posFb),
    .gain(posGain_r),
    .cmdOut(holdCmd)
  );

  // ****************************************************************
  // speed command
  // ****************************************************************
  // while held the command does not look at the reference; only the level check for release does
  always_ff @(posedge sysClk) begin
    if (rst) begin
      speedCmd_r <= 16'sh0;
    end else if (clampActive) begin
      speedCmd_r <= holdCmd;
    end else begin
      speedCmd_r <= filtRef;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence seqEnter;
    clamp_r == CLAMP_FREE && clampWant;
  endsequence

  sequence seqHeld;
    clamp_r == CLAMP_HOLD && holdPos_r == $past(posFb);
  endsequence

  chk_clamp_entry: assert property (@(posedge sysClk) disable iff (rst)
    seqEnter |=> seqHeld)
    else $error("clamp entry did not store the position");

  chk_cmd_source: assert property (@(posedge sysClk) disable iff (rst)
    clampActive |=> speedCmd_r == $past(holdCmd))
    else $error("reference reached the command while clamped");

  chk_request_open: assert property (@(posedge sysClk) disable iff (rst)
    (!allocMode_r && clampSel_r != CLAMPSEL_ALWAYS && !pconOn) |=> !clampActive)
    else $error("clamp held with the request open");

  chk_method_block: assert property (@(posedge sysClk) disable iff (rst)
    !(methodOk && modeOk) |=> !clampActive)
    else $error("clamp held in a method without clamping");

  chk_level_cap: assert property (@(posedge sysClk) disable iff (rst)
    (clampLevel_r > maxSpeed_r && szcAbs(32'(filtRef)) >= {16'h0000, maxSpeed_r})
    |=> !clampActive)
    else $error("clamp taken at or above the speed limit");

  chk_always_valid: assert property (@(posedge sysClk) disable iff (rst)
    (clampSel_r == CLAMPSEL_ALWAYS && activeCtrl == CTRL_SPEED && methodOk && belowLevel)
    |=> clampActive)
    else $error("always-valid clamp did not engage");

  chk_pin_select: assert property (@(posedge sysClk) disable iff (rst)
    (allocMode_r && clampSel_r < CLAMPSEL_ALWAYS && !clampPinOn[clampSel_r[2:0]])
    |=> !clampActive)
    else $error("clamp held with the selected pin open");

  chk_level_reset: assert property (@(posedge sysClk)
    $fell(rst) |-> clampLevel_r == LEVEL_RST && timeConst_r == TC_RST)
    else $error("setting reset value wrong");

  chk_method_a: assert property (@(posedge sysClk) disable iff (rst)
    (!allocMode_r && method_r == METHOD_ZERO_SW && clampSel_r != CLAMPSEL_ALWAYS)
    |-> clampReq == pconOn)
    else $error("method A does not follow the proportional input");

endmodule : szc_top

// file: sim/szc_host_model.sv
// host side model: plant that turns the speed command into feedback counts
// assumes speedCmd comes from the design and pushes come from the bench
`timescale 1ns/10ps
module szc_host_model (
  // clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // command from the drive and a bench-made disturbance
  input wire logic signed [15:0] speedCmd,
  input wire logic pushReq,
  input wire logic signed [31:0] pushAmt,
  // feedback count
  output logic signed [31:0] posFb
);
  // ****************************************************************
  // plant
  // ****************************************************************
  logic [2:0] divCnt_r;

  // one count per 8 cycles in the command sign, slow so the loop delay cannot overshoot
  always_ff @(posedge sysClk) begin
    if (rst) begin
      posFb <= 32'sh000003E8;
      divCnt_r <= 3'h0;
    end else if (pushReq) begin
      posFb <= posFb + pushAmt; // external force
    end else begin
      divCnt_r <= divCnt_r + 3'h1;
      if (divCnt_r == 3'h7 && speedCmd > 0) posFb <= posFb + 1;
      if (divCnt_r == 3'h7 && speedCmd < 0) posFb <= posFb - 1;
    end
  end
endmodule : szc_host_model

// file: sim/tb.sv
// bench for the speed reference filter and zero clamp, APB register access
// assumes zero-wait APB answers and the host model closing the feedback path
`timescale 1ns/10ps
module tb;
  import szc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic propCtrlInN = 1'b1;
  logic [6:0] clampPinsN = 7'h7F;
  logic ctrlSelectIn = 1'b0;
  logic signed [15:0] speedRefIn = 16'sh0000;
  logic pushReq = 1'b0;
  logic signed [31:0] pushAmt = 32'sh0;
  logic pready, pslverr, clampActive;
  logic [31:0] prdata;
  logic signed [31:0] posFb;
  logic signed [15:0] speedCmd_r;
  int n_fail = 0;
  int check_count = 0;

  always #25 sysClk = ~sysClk;

  szc_top u_szc_top (.sysClk(sysClk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .propCtrlInN(propCtrlInN), .clampPinsN(clampPinsN),
    .ctrlSelectIn(ctrlSelectIn), .speedRefIn(speedRefIn), .posFb(posFb),
    .speedCmd_r(speedCmd_r), .clampActive(clampActive));
  szc_host_model u_szc_host_model (.sysClk(sysClk), .rst(rst), .speedCmd(speedCmd_r),
    .pushReq(pushReq), .pushAmt(pushAmt), .posFb(posFb));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task report_and_stop;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task waitc(input int n);
    repeat (n) @(posedge sysClk);
  endtask : waitc

  // one transfer; entered just after an edge, leaves one idle cycle behind it
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for pready
    do begin
      @(posedge sysClk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sysClk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask : rd

  // poll status until the filtered reference leaves its old value
  task nextRef(input logic [15:0] prev, output logic [15:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS, q);
      n++;
    end while (q[31:16] === prev && n < 200);
    if (n >= 200) n_fail++;
    v = q[31:16];
  endtask : nextRef

  // pin syncs plus decision take 3 edges, 6 leaves margin
  task setClamp(input logic [31:0] mode, input logic exp);
    wr(OFS_MODE, mode);
    waitc(6);
    chk({31'h0, clampActive}, {31'h0, exp});
  endtask : setClamp

  task chkHold;
    logic [31:0] q;
    logic signed [31:0] dif;
    rd(OFS_HOLD_POS, q);
    dif = posFb - $signed(q);
    chk({31'h0, dif <= 1 && dif >= -1}, 32'h1);
  endtask : chkHold

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] v;
    logic [15:0] okLow;
    logic [15:0] okHigh;
    okLow = 16'h0479;  // methods 0,3,4,5,6,A with the select pin low
    okHigh = 16'h0699; // methods 0,3,4,7,9,A with the select pin high
    waitc(10);
    rst <= 1'b0;
    @(posedge sysClk);
    rd(OFS_FILT_TC, q);
    chk(q, 32'h28);
    rd(OFS_CLAMP_LEVEL, q);
    chk(q, 32'hA);
    xfer(1'b0, 8'h1C, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(OFS_CLAMP_LEVEL, 32'h4E20);
    rd(OFS_CLAMP_LEVEL, q);
    chk(q, 32'h2710);
    // lag steps: 1000/4 = 250, then 250 + 750/4 = 437
    wr(OFS_FILT_TC, 32'h0);
    waitc(250);
    wr(OFS_FILT_TC, 32'h4);
    speedRefIn <= 16'sd1000;
    nextRef(16'h0, v);
    chk({16'h0, v}, 32'hFA);
    nextRef(v, v);
    chk({16'h0, v}, 32'h1B5);
    wr(OFS_FILT_TC, 32'h0);
    nextRef(v, v);
    chk({16'h0, v}, 32'h3E8);
    speedRefIn <= 16'sd0;
    nextRef(v, v);
    chk({16'h0, v}, 32'h0);
    // every method against both states of the select pin, clamp pin 0 closed
    clampPinsN <= 7'h7E;
    for (int s = 0; s < 2; s++) begin
      ctrlSelectIn <= s[0];
      for (int m = 0; m < 16; m++) begin
        setClamp(32'h10 | m, s[0] ? okHigh[m] : okLow[m]);
      end
    end
    ctrlSelectIn <= 1'b0;
    // threshold capped by maximum speed
    wr(OFS_MAX_SPEED, 32'h5);
    wr(OFS_CLAMP_LEVEL, 32'h64);
    speedRefIn <= 16'sd6;
    nextRef(16'h0, v);
    setClamp(32'h10, 1'b0);
    speedRefIn <= 16'sd4;
    nextRef(v, v);
    setClamp(32'h10, 1'b1);
    wr(OFS_MAX_SPEED, 32'h1388);
    wr(OFS_CLAMP_LEVEL, 32'hA);
    speedRefIn <= 16'sd0;
    nextRef(v, v);
    // selected pin only, then the method A proportional input and allocation 7
    clampPinsN <= 7'h77;
    setClamp(32'h310, 1'b1);
    clampPinsN <= 7'h7E;
    setClamp(32'h310, 1'b0);
    setClamp(32'h810, 1'b0);
    clampPinsN <= 7'h7F;
    propCtrlInN <= 1'b0;
    setClamp(32'h80A, 1'b1);
    setClamp(32'h800, 1'b0);
    propCtrlInN <= 1'b1;
    setClamp(32'h80A, 1'b0);
    setClamp(32'h700, 1'b1);
    // hold, ignore reference, recover from a push
    waitc(20);
    chkHold();
    speedRefIn <= 16'sd8;
    waitc(250);
    chk({16'h0, speedCmd_r}, 32'h0);
    pushAmt <= 32'sd40;
    pushReq <= 1'b1;
    @(posedge sysClk);
    pushReq <= 1'b0;
    waitc(30);
    chk({31'h0, clampActive}, 32'h1);
    waitc(700);
    chkHold();
    report_and_stop();
  end

  // watchdog, well above the few thousand cycles the tests need
  initial begin
    #(50 * 40000);
    n_fail++;
    report_and_stop();
  end
endmodule : tb
